// File: design/spc_consts.svh
// Purpose: named constants of the serial port control block
// Assumes: included by the package and by the port module
// Notes:   counts are in character periods (char_tick_in strobes)
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH
`define SPC_A_CTRL      8'h00
`define SPC_A_STATUS    8'h04
`define SPC_A_RXDATA    8'h08
`define SPC_A_RXREL     8'h0c
`define SPC_HSIZE_WORD  3'h2
`define SPC_DIS_MIN     8'hc8
`define SPC_RDY_FLAGS   4'ha
`define SPC_BUF_BYTES   8'h87
`define SPC_NBUF        4
`define SPC_PTR_W       2
`endif

// File: design/spc_pkg.sv
// Purpose: types shared by the serial port control block
// Assumes: constants come from spc_consts.svh
// Notes:   register images are packed structs, lsb field last
`include "spc_consts.svh"
package spc_pkg;
	typedef enum logic [1:0] {SPC_DISABLED, SPC_ENABLED, SPC_READY,
		SPC_CHECK} spc_state_e;
	typedef enum logic [1:0] {SPC_WRAP, SPC_PRIV, SPC_NORMAL} spc_mode_e;
	typedef enum logic [1:0] {SPC_MR_NONE, SPC_MR_PRIV, SPC_MR_NORMAL,
		SPC_MR_WRAP} spc_modereq_e;
	typedef enum logic [1:0] {SPC_F_CTRL, SPC_F_PRIV, SPC_F_APP,
		SPC_F_RSVD} spc_ftype_e;
	typedef enum logic [2:0] {SPC_C_ZERO, SPC_C_DIS, SPC_C_FLAG, SPC_C_ACK,
		SPC_C_RR, SPC_C_DATA} spc_char_e;
	typedef enum logic [1:0] {SPC_SEL_NONE, SPC_SEL_DATA,
		SPC_SEL_CTL} spc_sel_e;
	// decoded receive events, one-cycle strobes
	typedef struct packed {
		logic       flag;      // flag character decoded
		logic       ack_pair;  // acknowledge pair received
		logic       rr_pair;   // buffer-ready pair received
		logic       start;     // frame header seen, ftype valid
		spc_ftype_e ftype;     // frame type at start
		logic       reset_frm; // total/reserved/absolute reset frame
		logic       link_rst;  // link reset frame received
		logic       byte_vld;  // data byte valid
		logic [7:0] data;      // frame byte
		logic       good_end;  // trailing flag, frame good
		logic       err;       // any detected link error
	} spc_rx_s;
	typedef struct packed {
		logic       req;   // frame waiting at the transmit pointer
		spc_ftype_e ftype; // its type
	} spc_txreq_s;
	typedef struct packed {
		logic [26:0]  rsv;
		logic         alert_exit; // recovery ended with alert code
		spc_modereq_e mode_req;
		logic         disable_cmd;
		logic         enable_cmd;
	} spc_ctrl_s;
	typedef struct packed {
		logic [28:0] rsv;
		logic        sel_ctl; // read the control buffer
		logic        rel_ctl;
		logic        rel_data;
	} spc_rel_s;
	typedef struct packed {
		logic [10:0] rsv;
		logic        sel_ctl;
		logic        ctl_full;
		logic        data_full;
		logic        err;
		logic        lrr;
		logic        rr_owed;
		logic        wait_rr;
		logic        ack_owed;
		logic        wait_ack;
		logic [1:0]  rseq;
		logic [1:0]  tseq;
		logic [1:0]  retry;
		logic [1:0]  txp;
		spc_mode_e   mode;
		spc_state_e  state;
	} spc_status_s;
endpackage

// File: design/spc_port.sv
// Purpose: per-port state, mode, pacing and buffer control of a serial link
// Assumes: receive decoder, transmit serializer on sys_clk_in; one
//          char_tick_in strobe per character period
// Notes:   registers on AHB-Lite, zero wait states, always OKAY
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`include "spc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module spc_port
	import spc_pkg::*;
(
	input  wire logic        sys_clk_in,
	input  wire logic        resetn_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic             hreadyout_out,
	output logic             hresp_out,
	output logic [31:0]      hrdata_out,
	input  wire logic        char_tick_in,
	input  wire spc_rx_s     rx_in,
	input  wire logic        line_fault_in,
	input  wire spc_txreq_s  tx_req_in,
	input  wire logic        tx_done_in,
	input  wire logic        tx_abort_in,
	output spc_char_e        tx_char_out,
	output logic             tx_go_out,
	output logic             tx_discard_out,
	output logic [3:0]       tx_held_out,
	output logic [1:0]       tx_ptr_out,
	output logic             line_zero_out,
	output logic             loopback_out
);
	// whole state of the port
	typedef struct packed {
		spc_state_e                      state;
		spc_mode_e                       mode;
		logic [7:0]                      dis_cnt;  // chars spent disabled
		logic [3:0]                      flags;    // flags sent in Ready
		logic [1:0]                      tseq;
		logic [1:0]                      rseq;
		logic                            wait_rr;
		logic                            rr_owed;
		logic                            wait_ack;
		logic                            ack_owed;
		logic                            lrr;      // link reset received
		logic                            err;      // error latch
		logic [`SPC_PTR_W-1:0]           txp;
		logic [`SPC_PTR_W-1:0]           retry;
		logic [`SPC_NBUF-1:0]            held;     // unacked tx buffers
		logic                            tx_busy;
		logic                            tx_go;
		logic                            tx_disc;
		spc_char_e                       tx_char;
		spc_sel_e                        rsel;     // current rx target
		logic                            racked;   // rx frame gets ack
		logic [7:0]                      widx;
		logic [`SPC_BUF_BYTES-1:0][7:0]  dbuf;
		logic [`SPC_BUF_BYTES-1:0][7:0]  cbuf;
		logic                            dfull;
		logic                            cfull;
		logic                            sel_ctl;
		logic [7:0]                      ridx;
		spc_ctrl_s                       cmd;      // pending commands
		logic                            wr_pend;
		logic [7:0]                      wr_addr;
		logic [31:0]                     hrdata;
		logic                            hresp;
		logic                            hready;
		logic                            lf1;      // fault synchroniser
		logic                            lf2;
		logic                            lf3;
		logic                            lf;       // filtered fault level
		logic                            wrap;     // wrap copy for the pins
	} spc_regs_s;

	spc_regs_s   r;        // registered state
	spc_regs_s   next_r;   // next state
	spc_status_s stat;     // status register image
	spc_ctrl_s   wctrl;    // write data seen as control
	spc_rel_s    wrel;     // write data seen as release

	assign wctrl = spc_ctrl_s'(hwdata_in);
	assign wrel  = spc_rel_s'(hwdata_in);

	// status image, state and mode as small fields
	always_comb begin
		stat           = '0;
		stat.state     = r.state;
		stat.mode      = r.mode;
		stat.txp       = r.txp;
		stat.retry     = r.retry;
		stat.tseq      = r.tseq;
		stat.rseq      = r.rseq;
		stat.wait_ack  = r.wait_ack;
		stat.ack_owed  = r.ack_owed;
		stat.wait_rr   = r.wait_rr;
		stat.rr_owed   = r.rr_owed;
		stat.lrr       = r.lrr;
		stat.err       = r.err;
		stat.data_full = r.dfull;
		stat.ctl_full  = r.cfull;
		stat.sel_ctl   = r.sel_ctl;
	end

	// next-state logic; later sections override earlier ones, so
	// hardware sets placed after software clears win the same cycle
	always_comb begin
		logic go_dis;   // enter Disabled this cycle
		logic app_like; // application or reserved frame
		logic tx_ok;    // a queued frame may start
		go_dis   = 1'b0;
		app_like = 1'b0;
		tx_ok    = 1'b0;
		next_r         = r;
		next_r.tx_go   = 1'b0;
		next_r.tx_disc = 1'b0;
		next_r.hready  = 1'b1;
		next_r.hresp   = 1'b0;
		next_r.wr_pend = 1'b0;

		// fault pin: three stages, change taken when stage 2 and 3 agree
		next_r.lf1 = line_fault_in;
		next_r.lf2 = r.lf1;
		next_r.lf3 = r.lf2;
		if (r.lf2 == r.lf3) begin
			next_r.lf = r.lf3;
		end

		// bus address phase; read data is ready for the data phase
		if (hsel_in && htrans_in[1] && hready_in) begin
			next_r.hrdata  = '0;
			next_r.wr_addr = haddr_in[7:0];
			next_r.wr_pend = hwrite_in && (hsize_in == `SPC_HSIZE_WORD);
			if (!hwrite_in && haddr_in[7:0] == `SPC_A_STATUS) begin
				next_r.hrdata = 32'(stat);
			end else if (!hwrite_in && haddr_in[7:0] == `SPC_A_RXDATA) begin
				// each read steps the read index through the buffer
				next_r.hrdata[7:0] = r.sel_ctl ? r.cbuf[r.ridx] :
					r.dbuf[r.ridx];
				if (r.ridx < `SPC_BUF_BYTES - 8'h01) begin
					next_r.ridx = r.ridx + 8'h01;
				end
			end
		end

		// bus data phase of a write
		if (r.wr_pend && r.wr_addr == `SPC_A_CTRL) begin
			// commands wait for the next character boundary
			next_r.cmd = wctrl;
		end else if (r.wr_pend && r.wr_addr == `SPC_A_RXREL) begin
			next_r.sel_ctl = wrel.sel_ctl;
			next_r.ridx    = '0;
			if (wrel.rel_data) begin
				next_r.dfull = 1'b0;
			end
			if (wrel.rel_ctl) begin
				next_r.cfull = 1'b0;
			end
		end

		// commands, taken only at a character boundary
		if (char_tick_in) begin
			if (r.cmd.mode_req == SPC_MR_NORMAL) begin
				next_r.mode = SPC_NORMAL;
			end else if (r.cmd.mode_req == SPC_MR_PRIV) begin
				next_r.mode = SPC_PRIV;
			end else if (r.cmd.mode_req == SPC_MR_WRAP) begin
				next_r.mode = SPC_WRAP;
			end
			if (r.cmd.alert_exit && r.mode == SPC_NORMAL) begin
				next_r.mode = SPC_PRIV;
			end
			next_r.cmd.mode_req   = SPC_MR_NONE;
			next_r.cmd.alert_exit = 1'b0;
			next_r.cmd.disable_cmd = 1'b0;
			if (r.cmd.disable_cmd) begin
				go_dis = 1'b1;
			end
			// enable waits until Disabled has lasted its minimum
			if (r.cmd.enable_cmd && (r.state != SPC_DISABLED ||
				r.dis_cnt >= `SPC_DIS_MIN)) begin
				next_r.cmd.enable_cmd = 1'b0;
				if (r.state == SPC_DISABLED) begin
					next_r.state = SPC_ENABLED;
				end
			end
			if (r.state == SPC_DISABLED && r.dis_cnt < `SPC_DIS_MIN) begin
				next_r.dis_cnt = r.dis_cnt + 8'h01;
			end
		end

		// automatic state changes
		unique case (r.state)
			SPC_DISABLED: begin
			end
			SPC_ENABLED: begin
				if (rx_in.flag) begin
					next_r.state = SPC_READY;
					next_r.flags = '0;
				end else if (r.lf && r.mode != SPC_WRAP) begin
					// wrap ignores the line fault detector
					next_r.state = SPC_CHECK;
				end
			end
			SPC_READY: begin
				if (rx_in.err || (rx_in.start && rx_in.link_rst)) begin
					next_r.state = SPC_CHECK;
				end
			end
			SPC_CHECK: begin
			end
		endcase
		if (rx_in.err) begin
			next_r.err = 1'b1;
		end
		if (rx_in.start && rx_in.link_rst && r.state != SPC_DISABLED) begin
			next_r.lrr = 1'b1;
		end

		// transmitter: one character per boundary, by priority
		if (char_tick_in) begin
			if (r.mode == SPC_WRAP && r.state == SPC_DISABLED) begin
				next_r.tx_char = SPC_C_DIS;
			end else if (r.state == SPC_DISABLED) begin
				next_r.tx_char = SPC_C_DIS;
			end else if (r.state == SPC_ENABLED) begin
				next_r.tx_char = SPC_C_FLAG;
			end else if (r.state == SPC_READY && r.flags < `SPC_RDY_FLAGS) begin
				next_r.tx_char = SPC_C_FLAG;
				next_r.flags   = r.flags + 4'h1;
			end else if (r.ack_owed) begin
				next_r.tx_char  = SPC_C_ACK;
				next_r.ack_owed = 1'b0;
			end else if (r.rr_owed && !r.dfull && r.state == SPC_READY) begin
				next_r.tx_char = SPC_C_RR;
				next_r.rr_owed = 1'b0;
			end else if (r.tx_busy) begin
				// a frame under way is finished even in Check
				next_r.tx_char = SPC_C_DATA;
			end else begin
				next_r.tx_char = SPC_C_FLAG;
				tx_ok = tx_req_in.req && !r.held[r.txp] && !r.tx_go;
			end
		end

		// start or discard the frame waiting at the transmit pointer
		app_like = tx_req_in.ftype == SPC_F_APP ||
			tx_req_in.ftype == SPC_F_RSVD;
		if (tx_ok && r.mode == SPC_PRIV && app_like &&
			r.state == SPC_READY) begin
			next_r.tx_disc = 1'b1;
		end else if (tx_ok && tx_req_in.ftype == SPC_F_CTRL &&
			r.state != SPC_ENABLED) begin
			next_r.tx_go   = 1'b1;
			next_r.tx_busy = 1'b1;
		end else if (tx_ok && r.state == SPC_READY && !r.wait_rr) begin
			// started only once a buffer-ready pair has cleared wait_rr
			next_r.tx_go   = 1'b1;
			next_r.tx_busy = 1'b1;
			next_r.wait_rr = 1'b1;
		end
		if (tx_abort_in) begin
			next_r.tx_busy = 1'b0;
		end

		// acknowledge pair frees the oldest held buffer
		if (rx_in.ack_pair && r.wait_ack) begin
			next_r.retry = r.retry + 2'h1;
			next_r.held[r.retry] = 1'b0;
			next_r.wait_ack = 1'b0;
		end
		if (rx_in.rr_pair && r.state != SPC_CHECK) begin
			next_r.wait_rr = 1'b0;
		end
		if (tx_done_in && !tx_abort_in) begin
			next_r.txp = r.txp + 2'h1;
			next_r.tseq = r.tseq + 2'h1;
			next_r.held[r.txp] = 1'b1;
			next_r.wait_ack = 1'b1;
			next_r.tx_busy = 1'b0;
		end

		// receiver: choose a buffer at frame start
		if (rx_in.start) begin
			next_r.rsel   = SPC_SEL_NONE;
			next_r.racked = 1'b0;
			next_r.widx   = '0;
			if (rx_in.ftype == SPC_F_CTRL && (r.state != SPC_DISABLED ||
				rx_in.reset_frm)) begin
				next_r.racked = 1'b1;
				if (!r.dfull) begin
					next_r.rsel = SPC_SEL_DATA;
				end else if (!r.cfull) begin
					next_r.rsel = SPC_SEL_CTL;
				end
			end else if (r.state == SPC_READY) begin
				// check and idle states drop these silently
				next_r.racked = 1'b1;
				if (r.mode == SPC_PRIV && rx_in.ftype != SPC_F_PRIV) begin
					next_r.rsel = SPC_SEL_NONE;
				end else if (!r.dfull) begin
					next_r.rsel = SPC_SEL_DATA;
				end
			end
		end

		// store bytes; overlong frames are clipped at the buffer end
		if (rx_in.byte_vld && r.widx < `SPC_BUF_BYTES) begin
			next_r.widx = r.widx + 8'h01;
			if (r.rsel == SPC_SEL_DATA) begin
				next_r.dbuf[r.widx] = rx_in.data;
			end else if (r.rsel == SPC_SEL_CTL) begin
				next_r.cbuf[r.widx] = rx_in.data;
			end
		end

		// frame end: fill, acknowledge and pace
		if (rx_in.good_end) begin
			next_r.rsel = SPC_SEL_NONE;
			if (r.rsel == SPC_SEL_DATA) begin
				next_r.dfull = 1'b1;
			end else if (r.rsel == SPC_SEL_CTL) begin
				next_r.cfull = 1'b1;
			end
			if (r.racked) begin
				next_r.ack_owed = 1'b1;
				next_r.rr_owed  = 1'b1;
				next_r.rseq     = r.rseq + 2'h1;
			end
			if (r.racked && rx_in.ftype == SPC_F_CTRL && rx_in.reset_frm) begin
				next_r.mode = SPC_PRIV;
				if (r.state != SPC_READY) begin
					go_dis = 1'b1;
				end
			end
		end

		// Disabled entry: only the listed items are initialised
		if (go_dis) begin
			next_r.state    = SPC_DISABLED;
			next_r.dis_cnt  = '0;
			next_r.lrr      = 1'b0;
			next_r.tseq     = '0;
			next_r.rseq     = '0;
			next_r.rr_owed  = 1'b1;
			next_r.wait_rr  = 1'b1;
			next_r.ack_owed = 1'b0;
			next_r.wait_ack = 1'b0;
			next_r.err      = 1'b0;
			next_r.tx_busy  = 1'b0;
		end
		// pins follow the mode from a flop of their own
		next_r.wrap = next_r.mode == SPC_WRAP;
	end

	// one register for the whole port
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			r         <= '0;
			r.state   <= SPC_DISABLED;
			r.mode    <= SPC_WRAP;
			r.wait_rr <= 1'b1;
			r.rr_owed <= 1'b1;
			r.tx_char <= SPC_C_DIS;
			r.hready  <= 1'b1;
			r.wrap    <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// outputs straight from the register
	assign hreadyout_out  = r.hready;
	assign hresp_out      = r.hresp;
	assign hrdata_out     = r.hrdata;
	assign tx_char_out    = r.tx_char;
	assign tx_go_out      = r.tx_go;
	assign tx_discard_out = r.tx_disc;
	assign tx_held_out    = r.held;
	assign tx_ptr_out     = r.txp;
	// wrap: serializer loops to the receiver, line held low
	assign line_zero_out  = r.wrap;
	assign loopback_out   = r.wrap;
endmodule
`default_nettype wire

// File: bench/spc_port_monitor.sv
// Purpose: port-level checks of the serial port control block
// Assumes: bound to spc_port; one clock, async active-low reset
// Notes:   only relations visible at the ports are checked
`timescale 1ns/1ps
`default_nettype none
module spc_port_monitor
	import spc_pkg::*;
(
	input wire logic       sys_clk_in,     // system clock
	input wire logic       resetn_in,      // async reset, active low
	input wire logic       hreadyout_out,  // bus ready
	input wire logic       hresp_out,      // bus response
	input wire logic       char_tick_in,   // character strobe
	input wire spc_rx_s    rx_in,          // receive events
	input wire logic       tx_done_in,     // trailing flag sent
	input wire logic       tx_go_out,      // start a frame
	input wire logic       tx_discard_out, // drop queued frame
	input wire logic [3:0] tx_held_out,    // unacked buffers
	input wire logic [1:0] tx_ptr_out,     // transmit pointer
	input wire spc_char_e  tx_char_out,    // character to send
	input wire logic       line_zero_out,  // outbound held low
	input wire logic       loopback_out    // internal loop
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);

	a_bus_okay: assert property (hreadyout_out && !hresp_out)
		else $error("bus slave not ready or not okay");
	a_wrap_pins: assert property (line_zero_out == loopback_out)
		else $error("wrap outputs disagree");
	a_tx_on_tick: assert property ((tx_go_out || tx_discard_out)
		|-> $past(char_tick_in))
		else $error("frame decision off a character boundary");
	a_go_or_drop: assert property (!(tx_go_out && tx_discard_out))
		else $error("frame both started and dropped");
	// the pointer may only move by one, and only after a trailing flag
	a_ptr_cause: assert property (tx_ptr_out != $past(tx_ptr_out)
		|-> $past(tx_done_in) && tx_ptr_out == $past(tx_ptr_out) + 2'h1)
		else $error("transmit pointer moved without a trailing flag");
	a_done_step: assert property (tx_done_in
		|=> tx_ptr_out == $past(tx_ptr_out) + 2'h1)
		else $error("trailing flag did not advance the pointer");
	a_held_cause: assert property (tx_held_out != $past(tx_held_out)
		|-> $past(tx_done_in || rx_in.ack_pair))
		else $error("held buffers changed without send or ack");
	a_held_set: assert property (tx_done_in
		|=> tx_held_out[$past(tx_ptr_out)])
		else $error("sent buffer not held");
	a_char_steady: assert property (!$past(char_tick_in)
		|-> $stable(tx_char_out))
		else $error("character changed between strobes");
	c_discard: cover property (tx_discard_out);
endmodule

bind spc_port spc_port_monitor spc_port_monitor_i (
	.sys_clk_in     (sys_clk_in),
	.resetn_in      (resetn_in),
	.hreadyout_out  (hreadyout_out),
	.hresp_out      (hresp_out),
	.char_tick_in   (char_tick_in),
	.rx_in          (rx_in),
	.tx_done_in     (tx_done_in),
	.tx_go_out      (tx_go_out),
	.tx_discard_out (tx_discard_out),
	.tx_held_out    (tx_held_out),
	.tx_ptr_out     (tx_ptr_out),
	.tx_char_out    (tx_char_out),
	.line_zero_out  (line_zero_out),
	.loopback_out   (loopback_out)
);
`default_nettype wire

// File: bench/spc_remote.sv
// Purpose: model of the remote port and the local frame source
// Assumes: events are driven just after a rising edge
// Notes:   slow stretches each frame so late trailing flags are tried
`timescale 1ns/1ps
`default_nettype none
module spc_remote
	import spc_pkg::*;
(
	input  wire logic     sys_clk_in,    // system clock
	input  wire logic     tx_go_in,      // port starts a frame
	input  wire logic     tx_discard_in, // port drops queued frame
	output var spc_rx_s   rx_out,        // decoded link events
	output var spc_txreq_s tx_req_out,   // frame waiting at pointer
	output logic          tx_done_out    // trailing flag sent
);
	int unsigned slow = 0; // extra cycles a frame spends on the line
	initial begin
		rx_out = '0;
		tx_req_out = '0;
		tx_done_out = 1'b0;
	end
	// idle byte lane keeps changing so a stale byte never looks valid
	always @(negedge sys_clk_in) begin
		if (!rx_out.byte_vld) begin
			rx_out.data <= ~rx_out.data;
		end
	end
	// one-cycle event, then all but the idle byte lane drops
	task automatic strobe(input spc_rx_s e);
		spc_rx_s idle;
		idle = '0;
		@(posedge sys_clk_in);
		e.data = rx_out.data;
		rx_out <= e;
		@(posedge sys_clk_in);
		idle.data = rx_out.data;
		rx_out <= idle;
	endtask
	task automatic queue_frame(input spc_ftype_e ft);
		@(posedge sys_clk_in);
		tx_req_out <= {1'b1, ft};
	endtask
	// a started frame ends slow+1 cycles later; dropped ones vanish
	always @(posedge sys_clk_in) begin
		tx_done_out <= 1'b0;
		if (tx_discard_in) begin
			tx_req_out.req <= 1'b0;
		end
		if (tx_go_in) begin
			tx_req_out.req <= 1'b0;
			repeat (slow + 1) @(posedge sys_clk_in);
			tx_done_out <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: bench/spc_port_test.sv
// Purpose: self-checking bench of the serial port control block
// Assumes: remote model supplies link events and frame requests
// Notes:   a character strobe every fourth clock keeps the run short
`include "spc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module spc_port_test import spc_pkg::*;;
	logic        sys_clk_in;          // 250 MHz
	logic        resetn_in = 1'b0;    // held low at start
	logic        hsel_in = 1'b0;
	logic [31:0] haddr_in = '0;
	logic [1:0]  htrans_in = '0;
	logic        hwrite_in = 1'b0;
	logic [2:0]  hsize_in = '0;
	logic [31:0] hwdata_in = '0;
	logic        hreadyout_out, hresp_out, tx_done, tx_go_out;
	logic [31:0] hrdata_out;
	logic        char_tick_in = 1'b0; // character strobe
	logic        line_fault = 1'b0;   // line fault pin
	logic [1:0]  phase = 2'h0;        // strobe divider
	spc_rx_s     rx_in;
	spc_txreq_s  tx_req;
	spc_char_e   tx_char_out;
	logic        tx_discard_out, line_zero_out, loopback_out;
	logic [3:0]  tx_held_out;
	logic [1:0]  tx_ptr_out, exp_ptr;
	spc_status_s sts;                 // last status read
	int          err_count = 0, n_checks = 0, n_ticks = 0;

	spc_port spc_port_i (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
		.hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
		.hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
		.hready_in(hreadyout_out), .hreadyout_out(hreadyout_out),
		.hresp_out(hresp_out), .hrdata_out(hrdata_out),
		.char_tick_in(char_tick_in), .rx_in(rx_in),
		.line_fault_in(line_fault),
		.tx_req_in(tx_req), .tx_done_in(tx_done), .tx_abort_in(1'b0),
		.tx_char_out(tx_char_out), .tx_go_out(tx_go_out),
		.tx_discard_out(tx_discard_out), .tx_held_out(tx_held_out),
		.tx_ptr_out(tx_ptr_out), .line_zero_out(line_zero_out),
		.loopback_out(loopback_out));
	spc_remote spc_remote_i (.sys_clk_in(sys_clk_in), .tx_go_in(tx_go_out),
		.tx_discard_in(tx_discard_out), .rx_out(rx_in),
		.tx_req_out(tx_req), .tx_done_out(tx_done));

	initial begin
		sys_clk_in = 1'b0;
		forever #2 sys_clk_in = ~sys_clk_in;
	end
	// strobes counted from reset release, as the port counts them
	always @(posedge sys_clk_in) begin
		phase <= phase + 2'h1;
		char_tick_in <= (phase == 2'h2);
		n_ticks <= resetn_in ? n_ticks + int'(char_tick_in) : 0;
	end
	// one single word transfer; waits as long as the slave stalls
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge sys_clk_in);
		{hsel_in, htrans_in, hwrite_in} <= {1'b1, 2'h2, w};
		haddr_in <= {24'h0, a};
		hsize_in <= `SPC_HSIZE_WORD;
		@(posedge sys_clk_in);
		while (hreadyout_out !== 1'b1) @(posedge sys_clk_in);
		{hsel_in, htrans_in} <= 3'h0;
		hwdata_in <= d;
		@(posedge sys_clk_in);
		while (hreadyout_out !== 1'b1) @(posedge sys_clk_in);
		q = hrdata_out;
	endtask
	task automatic st();
		logic [31:0] q;
		bus(1'b0, `SPC_A_STATUS, 32'h0, q);
		sts = spc_status_s'(q);
	endtask
	// bounded wait for state/mode bits to reach a value
	task automatic poll(input logic [3:0] want, input logic [3:0] mask);
		for (int i = 0; i < 400; i++) begin
			st();
			if ((sts[3:0] & mask) == want) break;
		end
	endtask
	task automatic wait_hi(input bit drop, output bit seen);
		seen = 1'b0;
		repeat (300) begin
			@(posedge sys_clk_in);
			if ((drop ? tx_discard_out : tx_done) === 1'b1) begin
				seen = 1'b1;
				break;
			end
		end
	endtask
	task automatic tick_char();
		@(posedge sys_clk_in iff char_tick_in);
		@(negedge sys_clk_in);
	endtask
	function automatic spc_rx_s rx_ev(input int k);
		rx_ev = '0;
		rx_ev.flag = (k == 0);
		rx_ev.ack_pair = (k == 1);
		rx_ev.rr_pair = (k == 2);
		rx_ev.err = (k == 3);
		rx_ev.reset_frm = (k == 4 || k == 5);
		rx_ev.start = (k == 4 || k == 6);
		rx_ev.good_end = (k == 5 || k == 7);
		if (k > 5) rx_ev.ftype = SPC_F_APP;
	endfunction
	task automatic stop_test();
		if (err_count == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge sys_clk_in);
		err_count++;
		stop_test();
	end

	initial begin
		logic [31:0] q;
		logic [7:0]  a;
		bit          seen;
		q = $urandom(32'h69cd);
		repeat (12) @(posedge sys_clk_in);
		resetn_in <= 1'b1;
		@(negedge sys_clk_in);
		`CHK({line_zero_out, loopback_out, tx_ptr_out, tx_held_out}, 8'hc0)
		`CHK(tx_char_out, SPC_C_DIS)
		st();
		`CHK(sts, 32'h0000c000)
		// unmapped places and status refuse random writes
		for (int i = 0; i < 4; i++) begin
			a = 8'h10 + 8'($urandom_range(0, 59)) * 8'h4;
			bus(1'b1, a, $urandom, q);
			bus(1'b1, `SPC_A_STATUS, $urandom, q);
			bus(1'b0, a, 32'h0, q);
			`CHK(q, 32'h0)
		end
		st();
		`CHK(sts, 32'h0000c000)
		bus(1'b1, `SPC_A_CTRL, 32'h5, q);
		poll(4'h4, 4'hc);
		`CHK({sts.state, line_zero_out}, {SPC_DISABLED, 1'b0})
		poll({2'h0, SPC_ENABLED}, 4'h3);
		`CHK(n_ticks >= int'(`SPC_DIS_MIN), 1'b1)
		tick_char();
		`CHK(tx_char_out, SPC_C_FLAG)
		spc_remote_i.strobe(rx_ev(0));
		repeat (`SPC_RDY_FLAGS) begin
			tick_char();
			`CHK(tx_char_out, SPC_C_FLAG)
		end
		st();
		`CHK(sts.state, SPC_READY)
		spc_remote_i.strobe(rx_ev(2));
		spc_remote_i.queue_frame(SPC_F_APP);
		wait_hi(1'b1, seen);
		`CHK(seen, 1'b1)
		spc_remote_i.strobe(rx_ev(6));
		spc_remote_i.strobe(rx_ev(7));
		st();
		`CHK({sts.rseq, sts.tseq, sts.txp}, 6'h10)
		bus(1'b1, `SPC_A_CTRL, 32'h8, q);
		poll(4'h8, 4'hc);
		`CHK(sts.mode, SPC_NORMAL)
		exp_ptr = 2'h0;
		for (int i = 0; i < 3; i++) begin
			spc_remote_i.slow = $urandom_range(0, 12);
			spc_remote_i.queue_frame(i == 1 ? SPC_F_CTRL : SPC_F_APP);
			wait_hi(1'b0, seen);
			@(negedge sys_clk_in);
			`CHK({seen, tx_ptr_out}, {1'b1, exp_ptr + 2'h1})
			`CHK(tx_held_out[exp_ptr], 1'b1)
			spc_remote_i.strobe(rx_ev(1));
			spc_remote_i.strobe(rx_ev(2));
			@(negedge sys_clk_in);
			`CHK(tx_held_out, 4'h0)
			exp_ptr++;
		end
		st();
		`CHK(sts.retry, exp_ptr)
		spc_remote_i.strobe(rx_ev(3));
		poll({2'h0, SPC_CHECK}, 4'h3);
		`CHK(sts.state, SPC_CHECK)
		bus(1'b1, `SPC_A_CTRL, 32'h2, q);
		poll({2'h0, SPC_DISABLED}, 4'h3);
		`CHK(sts[17:8], 10'h0c0)
		`CHK({sts.mode, sts.retry, sts.txp}, {SPC_NORMAL, exp_ptr, exp_ptr})
		tick_char();
		`CHK(tx_char_out, SPC_C_DIS)
		spc_remote_i.strobe(rx_ev(4));
		spc_remote_i.strobe(rx_ev(5));
		poll(4'h4, 4'hc);
		`CHK(sts.mode, SPC_PRIV)
		// line fault while Enabled leads to Check
		bus(1'b1, `SPC_A_CTRL, 32'h1, q);
		poll({2'h0, SPC_ENABLED}, 4'h3);
		`CHK(sts.state, SPC_ENABLED)
		line_fault <= 1'b1;
		poll({2'h0, SPC_CHECK}, 4'h3);
		`CHK(sts.state, SPC_CHECK)
		stop_test();
	end
endmodule
`default_nettype wire
